// ---- isvu_pkg.sv ----
package isvu_pkg;
    localparam int N_SRC = 21;
    localparam int N_LVL = 4;
    localparam int LVL_W = 2;
    localparam int PC_W = 20;
    localparam int PSW_W = 16;
    localparam int CTX_W = PC_W + PSW_W;
    localparam int VEC_W = 16;
    localparam int SRC_W = 5;
    localparam int BANK_W = 3;
    localparam int BANK_N = 8;
    localparam int N_TMR = 4;
    localparam int CNT_W = 16;
    localparam int NARROW_W = 8;
    localparam int TMR_SRC_LO = 4;
    localparam int TMR_SRC_HI = 10;
    localparam int N_CMP = TMR_SRC_HI - TMR_SRC_LO + 1;
    // two compare units per timer except timer three, which has one; each a maskable source, timer zero always wide
    localparam int CMP_PER_TMR = 2;
    // ************************************************************
    // sources able to use macro service (reception errors are not)
    // ************************************************************
    localparam logic [N_SRC-1:0] MACRO_CAPABLE = 21'h1bbfff;
    localparam logic [7:0] OPERAND_CHECK_OK = 8'hff;
    localparam logic [2:0] LEVEL_NONE = 3'h4;
    localparam logic [SRC_W-1:0] SRC_BRK = 5'h15;
    localparam logic [SRC_W-1:0] SRC_BANK_SWITCH_BREAK_INSTRUCTION = 5'h16;
    localparam logic [SRC_W-1:0] SRC_OPERR = 5'h17;
    localparam logic [SRC_W-1:0] SRC_NMI = 5'h18;
    localparam logic [SRC_W-1:0] SRC_WDT = 5'h19;
    localparam logic [VEC_W-1:0] VEC_NMI = 16'h0002;
    localparam logic [VEC_W-1:0] VEC_WDT = 16'h0004;
    localparam logic [VEC_W-1:0] VEC_MASK_BASE = 16'h0006;
    localparam logic [VEC_W-1:0] VEC_OPERR = 16'h003c;
    localparam logic [VEC_W-1:0] VEC_BRK = 16'h003e;

    // maskable entries are two bytes apart from the base, in priority order
    function automatic logic [VEC_W-1:0] vector_of(
        input logic [SRC_W-1:0] s);
        case (s)
            SRC_BRK: vector_of = VEC_BRK;
            SRC_OPERR: vector_of = VEC_OPERR;
            SRC_NMI: vector_of = VEC_NMI;
            SRC_WDT: vector_of = VEC_WDT;
            default: vector_of = VEC_MASK_BASE + VEC_W'({s, 1'b0});
        endcase
    endfunction
endpackage

// ---- bank_store_mem.sv ----
`timescale 1ns/1ns
// one word per register bank, read data registered
module bank_store_mem #(
    parameter int W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [isvu_pkg::BANK_W-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    input wire logic [isvu_pkg::BANK_W-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    import isvu_pkg::*;
    logic [W-1:0] mem [0:BANK_N-1];
    logic [W-1:0] rdata_r;

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem[i_raddr];
        end
    end

    assign o_rdata = rdata_r;
endmodule

// ---- interrupt_source_vector_unit.sv ----
`timescale 1ns/1ns
// Behaviour
// R1 - four pin edges take priorities zero to three
// R2 - third pin edge vectors to 000AH
// R3 - timer zero matches raise priorities four, five
// R4 - timers one-three compare eight or sixteen bits
// R5 - conversion done priority 13, vector 0020H
// R6 - channel zero receive request priority 15, 0024H
// R7 - channel two receive 002CH, transmit 002EH
// R8 - vectored branch fetches fixed table entry
// R9 - bad immediate check byte raises operand error
// R10 - pin edge raises unmaskable request
// R11 - vectored branch pushes counter and status first
// R12 - return pops status and counter
// R13 - handler addresses stay below 10000H
// R14 - context switch saves into bank, branches
// R15 - macro service moves data in one cycle; here S_MACRO holds o_macro_req until i_macro_ack, however many cycles
// R16 - macro service leaves counter, status untouched
// R17 - equal levels granted in default order
// R18 - four levels gate nesting; macro never suspended
// R19 - watchdog overflow is unmaskable, precedence selectable
// R20 - accepted request clears its pending flag
// R21 - macro service only for capable maskable sources
module interrupt_source_vector_unit (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [isvu_pkg::N_SRC-1:0] i_mask_req,
    input wire logic [isvu_pkg::N_TMR*isvu_pkg::CNT_W-1:0] i_timer_count,
    input wire logic [isvu_pkg::N_TMR-1:0] i_timer_wide,
    input wire logic [isvu_pkg::N_CMP*isvu_pkg::CNT_W-1:0] i_compare,
    input wire logic i_nmi_edge,
    input wire logic i_watchdog_overflow_request,
    input wire logic i_wdt_first,
    input wire logic i_break_instruction,
    input wire logic i_bank_switch_break_instruction,
    input wire logic [isvu_pkg::BANK_W-1:0] i_bank_switch_break_instruction_bank,
    input wire logic i_imm_store,
    input wire logic [7:0] i_imm_operand,
    input wire logic [7:0] i_imm_check,
    input wire logic i_return_from_interrupt,
    input wire logic i_ctx_return,
    input wire logic [isvu_pkg::BANK_W-1:0] i_ctx_return_bank,
    input wire logic [isvu_pkg::N_SRC-1:0] i_mask,
    input wire logic [isvu_pkg::N_SRC*isvu_pkg::LVL_W-1:0] i_level,
    input wire logic [isvu_pkg::N_SRC-1:0] i_ctx_sel,
    input wire logic [isvu_pkg::N_SRC-1:0] i_macro_sel,
    input wire logic i_irq_enable,
    input wire logic [2:0] i_service_level,
    input wire logic [isvu_pkg::PC_W-1:0] i_pc,
    input wire logic [isvu_pkg::PSW_W-1:0] i_program_status_word,
    input wire logic i_vec_valid,
    input wire logic [isvu_pkg::VEC_W-1:0] i_vec_data,
    input wire logic i_stack_valid,
    input wire logic [isvu_pkg::CTX_W-1:0] i_stack_data,
    input wire logic i_macro_ack,
    input wire logic i_bank_vec_we,
    input wire logic [isvu_pkg::BANK_W-1:0] i_bank_vec_addr,
    input wire logic [isvu_pkg::VEC_W-1:0] i_bank_vec_data,
    output logic o_busy,
    output logic o_stack_push,
    output logic [isvu_pkg::CTX_W-1:0] o_stack_data,
    output logic o_stack_pop,
    output logic o_vec_rd,
    output logic [isvu_pkg::VEC_W-1:0] o_vec_addr,
    output logic o_branch,
    output logic [isvu_pkg::VEC_W-1:0] o_branch_addr,
    output logic o_macro_req,
    output logic [isvu_pkg::SRC_W-1:0] o_macro_src,
    output logic o_resume,
    output logic [isvu_pkg::PC_W-1:0] o_resume_pc,
    output logic [isvu_pkg::PSW_W-1:0] o_resume_psw
);
    import isvu_pkg::*;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_PUSH = 9'h002,
        S_FETCH = 9'h004,
        S_BRANCH = 9'h008,
        S_CTX_RD = 9'h010,
        S_MACRO = 9'h020,
        S_POP = 9'h040,
        S_CTX_RET = 9'h080,
        S_RESUME = 9'h100
    } state_e;

    state_e state_r, state_nxt;
    logic [N_SRC-1:0] pend_r, pend_nxt, match_r, hit, req_in, clr_vec;
    logic brk_r, brk_nxt, bank_switch_break_instruction_r, bank_switch_break_instruction_nxt, operr_r, operr_nxt;
    logic nmi_r, nmi_nxt, wdt_r, wdt_nxt;
    logic [BANK_W-1:0] bank_switch_break_instruction_bank_r, bank_switch_break_instruction_bank_nxt;
    logic [SRC_W-1:0] src_r, src_nxt, win, sel_src;
    logic [VEC_W-1:0] vec_addr_r, vec_addr_nxt, br_r, br_nxt, vec_rdata;
    logic [CTX_W-1:0] save_r, save_nxt, res_r, res_nxt, ctx_rdata;
    logic [BANK_W-1:0] sel_bank;
    logic [LVL_W-1:0] win_lvl;
    logic found, sel_valid, sel_ctx, sel_mac, take, take_mask, bad_operand;

    // ************************************************************
    // request capture
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_src
            if (g >= TMR_SRC_LO && g <= TMR_SRC_HI) begin : g_tmr
                localparam int T = (g - TMR_SRC_LO) / CMP_PER_TMR;
                logic [CNT_W-1:0] cnt, cmp;
                assign cnt = i_timer_count[T*CNT_W +: CNT_W];
                assign cmp = i_compare[(g-TMR_SRC_LO)*CNT_W +: CNT_W];
                // timer zero has no narrow mode  [R3]
                assign hit[g] = (T == 0 || i_timer_wide[T]) ? cnt == cmp :
                    cnt[NARROW_W-1:0] == cmp[NARROW_W-1:0]; // [R4]
            end else begin : g_pin
                assign hit[g] = 1'b0;
            end
            // one request per match, not per cycle the match lasts
            assign req_in[g] = i_mask_req[g] | (hit[g] & ~match_r[g]);
            // a new request beats the clear of the same cycle  [R20]
            assign pend_nxt[g] = req_in[g] | (pend_r[g] & ~clr_vec[g]);
        end
    endgenerate

    assign bad_operand = i_imm_store &&
        ((i_imm_operand ^ i_imm_check) != OPERAND_CHECK_OK); // [R9]

    // ************************************************************
    // arbitration
    // ************************************************************
    always_comb begin
        logic [LVL_W-1:0] lv;
        lv = '0;
        win = '0;
        win_lvl = '0;
        found = 1'b0;
        // last hit wins: lowest level, then lowest default number [R17]
        for (int l = N_LVL - 1; l >= 0; l--) begin
            for (int i = N_SRC - 1; i >= 0; i--) begin
                lv = i_level[i*LVL_W +: LVL_W];
                // macro sources skip the nesting check  [R18]
                if (pend_r[i] && !i_mask[i] && lv == LVL_W'(l) &&
                    ((i_macro_sel[i] && MACRO_CAPABLE[i]) ||
                    (i_irq_enable && {1'b0, lv} < i_service_level))) begin
                    win = SRC_W'(i);
                    win_lvl = lv;
                    found = 1'b1;
                end
            end
        end
    end

    always_comb begin
        sel_valid = 1'b1;
        sel_ctx = 1'b0;
        sel_mac = 1'b0;
        sel_bank = bank_switch_break_instruction_bank_r;
        sel_src = win;
        if (operr_r) begin
            sel_src = SRC_OPERR;
        end else if (brk_r) begin
            sel_src = SRC_BRK;
        end else if (bank_switch_break_instruction_r) begin
            sel_src = SRC_BANK_SWITCH_BREAK_INSTRUCTION;
            sel_ctx = 1'b1; // [R14]
        end else if (wdt_r && (i_wdt_first || !nmi_r)) begin
            sel_src = SRC_WDT; // [R19]
        end else if (nmi_r) begin
            sel_src = SRC_NMI; // [R10]
        end else if (found) begin
            // fixed-order table puts pins first, then timers  [R1]
            sel_ctx = i_ctx_sel[win];
            sel_mac = i_macro_sel[win] && MACRO_CAPABLE[win]; // [R21]
            sel_bank = {1'b0, win_lvl};
        end else begin
            sel_valid = 1'b0;
        end
    end

    // ************************************************************
    // handling sequence
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        src_nxt = src_r;
        vec_addr_nxt = vec_addr_r;
        br_nxt = br_r;
        save_nxt = save_r;
        res_nxt = res_r;
        take = 1'b0;
        unique case (state_r)
            S_IDLE: begin
                if (i_return_from_interrupt) begin
                    state_nxt = S_POP;
                end else if (i_ctx_return) begin
                    state_nxt = S_CTX_RET;
                end else if (sel_valid) begin
                    take = 1'b1;
                    src_nxt = sel_src;
                    vec_addr_nxt = vector_of(sel_src); // [R2] [R5] [R6] [R7]
                    save_nxt = {i_program_status_word, i_pc};
                    if (sel_mac) begin
                        state_nxt = S_MACRO;
                    end else if (sel_ctx) begin
                        state_nxt = S_CTX_RD;
                    end else begin
                        state_nxt = S_PUSH;
                    end
                end
            end
            S_PUSH: state_nxt = S_FETCH; // [R11]
            S_FETCH: begin
                if (i_vec_valid) begin
                    br_nxt = i_vec_data; // [R8] [R13]
                    state_nxt = S_BRANCH;
                end
            end
            S_CTX_RD: begin
                br_nxt = vec_rdata; // [R14]
                state_nxt = S_BRANCH;
            end
            S_BRANCH: state_nxt = S_IDLE;
            // counter and status stay with the core  [R15] [R16]
            S_MACRO: begin
                if (i_macro_ack) begin
                    state_nxt = S_IDLE;
                end
            end
            S_POP: begin
                if (i_stack_valid) begin
                    res_nxt = i_stack_data; // [R12]
                    state_nxt = S_RESUME;
                end
            end
            S_CTX_RET: begin
                res_nxt = ctx_rdata;
                state_nxt = S_RESUME;
            end
            S_RESUME: state_nxt = S_IDLE;
        endcase
    end

    assign take_mask = take && sel_src < SRC_W'(N_SRC);
    assign clr_vec = take_mask ? (N_SRC'(1) << win) : '0; // [R20]

    always_comb begin
        operr_nxt = bad_operand | (operr_r & ~(take && sel_src == SRC_OPERR));
        brk_nxt = i_break_instruction | (brk_r & ~(take && sel_src == SRC_BRK));
        bank_switch_break_instruction_nxt = i_bank_switch_break_instruction |
            (bank_switch_break_instruction_r & ~(take && sel_src == SRC_BANK_SWITCH_BREAK_INSTRUCTION));
        bank_switch_break_instruction_bank_nxt = i_bank_switch_break_instruction ? i_bank_switch_break_instruction_bank :
            bank_switch_break_instruction_bank_r;
        nmi_nxt = i_nmi_edge | (nmi_r & ~(take && sel_src == SRC_NMI));
        wdt_nxt = i_watchdog_overflow_request |
            (wdt_r & ~(take && sel_src == SRC_WDT)); // [R19]
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= S_IDLE;
            pend_r <= '0;
            match_r <= '0;
            {operr_r, brk_r, bank_switch_break_instruction_r, nmi_r, wdt_r} <= '0;
            bank_switch_break_instruction_bank_r <= '0;
            src_r <= '0;
            vec_addr_r <= '0;
            br_r <= '0;
            save_r <= '0;
            res_r <= '0;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            match_r <= hit;
            {operr_r, brk_r, bank_switch_break_instruction_r, nmi_r, wdt_r} <=
                {operr_nxt, brk_nxt, bank_switch_break_instruction_nxt, nmi_nxt, wdt_nxt};
            bank_switch_break_instruction_bank_r <= bank_switch_break_instruction_bank_nxt;
            src_r <= src_nxt;
            vec_addr_r <= vec_addr_nxt;
            br_r <= br_nxt;
            save_r <= save_nxt;
            res_r <= res_nxt;
        end
    end

    // vector held per bank, and the context saved on switching
    bank_store_mem #(.W(VEC_W)) u_bank_vec (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_bank_vec_we),
        .i_waddr(i_bank_vec_addr),
        .i_wdata(i_bank_vec_data),
        .i_raddr(sel_bank),
        .o_rdata(vec_rdata)
    );

    bank_store_mem #(.W(CTX_W)) u_bank_ctx (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(take && sel_ctx),
        .i_waddr(sel_bank),
        .i_wdata({i_program_status_word, i_pc}),
        .i_raddr(i_ctx_return_bank),
        .o_rdata(ctx_rdata)
    );

    assign o_busy = state_r != S_IDLE;
    assign o_stack_push = state_r == S_PUSH;
    assign o_stack_data = save_r;
    assign o_stack_pop = state_r == S_POP;
    assign o_vec_rd = state_r == S_FETCH;
    assign o_vec_addr = vec_addr_r;
    assign o_branch = state_r == S_BRANCH;
    assign o_branch_addr = br_r;
    assign o_macro_req = state_r == S_MACRO;
    assign o_macro_src = src_r;
    assign o_resume = state_r == S_RESUME;
    assign o_resume_pc = res_r[PC_W-1:0];
    assign o_resume_psw = res_r[PC_W +: PSW_W];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_pin_c_vector: assert property ( // [R2]
        $rose(o_vec_rd) && src_r == 5'h02 |-> o_vec_addr == 16'h000a)
        else $error("third pin edge vector wrong");
    chk_push_first: assert property ( // [R11]
        $rose(o_vec_rd) |-> $past(o_stack_push))
        else $error("vector fetched without stack push");
    chk_pop_resume: assert property ( // [R12]
        o_stack_pop && i_stack_valid |=> o_resume ##1 !o_resume)
        else $error("pop did not resume");
    chk_macro_quiet: assert property ( // [R16]
        o_macro_req |-> !o_stack_push && !o_stack_pop && !o_branch)
        else $error("macro service touched cpu status");
    chk_operand_err: assert property ( // [R9]
        i_imm_store && (i_imm_operand ^ i_imm_check) != 8'hff |=> operr_r)
        else $error("operand error not raised");
    chk_nmi_sticky: assert property ( // [R10]
        i_nmi_edge |=> nmi_r)
        else $error("pin edge lost");
    chk_macro_capable: assert property ( // [R21]
        $rose(o_macro_req) |-> src_r < 5'h15 && MACRO_CAPABLE[src_r])
        else $error("macro service on incapable source");
    chk_pend_clear: assert property ( // [R20]
        take_mask && !req_in[win] |=> !pend_r[$past(win)])
        else $error("pending flag not cleared on accept");
    chk_ctx_branch: assert property ( // [R14]
        state_r == S_CTX_RD |=> o_branch && o_branch_addr == $past(vec_rdata))
        else $error("context branch address wrong");
    chk_vector_fetch: assert property ( // [R8]
        take && !sel_mac && !sel_ctx |=> ##1 o_vec_rd &&
        o_vec_addr == vector_of(src_r))
        else $error("vector table entry not fetched");

    cov_vectored: cover property (o_stack_push ##1 o_vec_rd ##[1:3] o_branch);
    cov_context: cover property (state_r == S_CTX_RD ##1 o_branch);
    cov_macro: cover property (o_macro_req ##1 !o_macro_req);
    cov_return: cover property (o_stack_pop ##1 o_resume);
endmodule

// ---- cpu_side_model.sv ----
`timescale 1ns/1ns
module cpu_side_model (
    input wire logic i_clk,
    input wire logic [1:0] i_delay,
    input wire logic i_stack_push,
    input wire logic [isvu_pkg::CTX_W-1:0] i_stack_data,
    input wire logic i_stack_pop,
    input wire logic i_vec_rd,
    input wire logic [isvu_pkg::VEC_W-1:0] i_vec_addr,
    input wire logic i_macro_req,
    output logic o_vec_valid,
    output logic [isvu_pkg::VEC_W-1:0] o_vec_data,
    output logic o_stack_valid,
    output logic [isvu_pkg::CTX_W-1:0] o_stack_data,
    output logic o_macro_ack
);
    import isvu_pkg::*;
    logic [CTX_W-1:0] stack_q[$];
    int wait_cnt = 0;
    initial begin
        o_vec_valid = 1'b0;
        o_vec_data = '0;
        o_stack_valid = 1'b0;
        o_stack_data = '0;
        o_macro_ack = 1'b0;
    end
    // ********
    // stack frames kept newest last, so a pop takes the latest push
    // ********
    always @(posedge i_clk) begin
        if (i_stack_push === 1'b1) begin
            stack_q.push_back(i_stack_data);
        end
    end
    // answers move on the falling edge, clear of the sampling edge
    always @(negedge i_clk) begin
        if (o_vec_valid || o_stack_valid || o_macro_ack) begin
            o_vec_valid <= 1'b0;
            o_stack_valid <= 1'b0;
            o_macro_ack <= 1'b0;
            // released lines must not keep looking valid
            o_vec_data <= ~o_vec_data;
            o_stack_data <= ~o_stack_data;
            wait_cnt <= 0;
        end else if (i_vec_rd || i_stack_pop || i_macro_req) begin
            if (wait_cnt < int'(i_delay)) begin
                wait_cnt <= wait_cnt + 1;
            end else if (i_vec_rd) begin
                o_vec_valid <= 1'b1;
                o_vec_data <= i_vec_addr ^ 16'h8000;
            end else if (i_stack_pop) begin
                o_stack_valid <= 1'b1;
                o_stack_data <= stack_q.pop_back();
            end else begin
                o_macro_ack <= 1'b1;
            end
        end
    end
endmodule

// ---- interrupt_source_vector_unit_tb.sv ----
`timescale 1ns/1ns
module interrupt_source_vector_unit_tb;
    import isvu_pkg::*;
    typedef struct packed {
        logic [7:0] p;
        logic [SRC_W-1:0] src;
        logic [VEC_W-1:0] vec;
    } row_s;
    localparam logic [VEC_W-1:0] VEC_TAB [0:20] = '{
        16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010,
        16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c,
        16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028,
        16'h002a, 16'h002c, 16'h002e};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] pulse = '0;
    logic [1:0] delay = '0;
    logic [N_SRC-1:0] i_mask_req = '0;
    logic [N_SRC-1:0] i_mask = '0;
    logic [N_SRC-1:0] i_ctx_sel = '0;
    logic [N_SRC-1:0] i_macro_sel = '0;
    logic [N_TMR*CNT_W-1:0] i_timer_count = 64'h0000_0000_1234_0000;
    logic [N_TMR-1:0] i_timer_wide = 4'hf;
    logic [N_CMP*CNT_W-1:0] i_compare = '1;
    logic i_wdt_first = 1'b0;
    logic i_irq_enable = 1'b1;
    logic i_bank_vec_we = 1'b0;
    logic [BANK_W-1:0] i_bank_switch_break_instruction_bank = 3'h5;
    logic [BANK_W-1:0] i_ctx_return_bank = '0;
    logic [BANK_W-1:0] i_bank_vec_addr = '0;
    logic [VEC_W-1:0] i_bank_vec_data = 16'h4321;
    logic [7:0] i_imm_operand = 8'h5a;
    logic [7:0] i_imm_check = 8'ha4;
    logic [N_SRC*LVL_W-1:0] i_level = '0;
    logic [2:0] i_service_level = 3'h4;
    logic [PC_W-1:0] i_pc = 20'h10000;
    logic [PSW_W-1:0] i_program_status_word = 16'ha500;
    logic i_break_instruction, i_imm_store, i_nmi_edge;
    logic i_watchdog_overflow_request, i_bank_switch_break_instruction;
    logic i_return_from_interrupt, i_ctx_return;
    logic i_vec_valid, i_stack_valid, i_macro_ack;
    logic [VEC_W-1:0] i_vec_data, o_vec_addr, o_branch_addr;
    logic [CTX_W-1:0] i_stack_data, o_stack_data;
    logic o_busy, o_stack_push, o_stack_pop, o_vec_rd, o_branch;
    logic o_macro_req, o_resume;
    logic [SRC_W-1:0] o_macro_src;
    logic [PC_W-1:0] o_resume_pc;
    logic [PSW_W-1:0] o_resume_psw;
    logic [6:0] ev;
    int fails = 0, check_count = 0, push_cnt = 0, n, p;
    row_s rows [0:24];
    assign {i_ctx_return, i_return_from_interrupt,
        i_bank_switch_break_instruction, i_watchdog_overflow_request,
        i_nmi_edge, i_imm_store, i_break_instruction} = pulse[7:1];
    assign ev = {~o_busy, o_resume, o_macro_req, o_branch, o_vec_rd,
        o_stack_pop, o_stack_push};
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_stack_push === 1'b1) push_cnt++;
    interrupt_source_vector_unit i_dut (.*);
    cpu_side_model i_cpu (.i_clk(i_clk), .i_delay(delay),
        .i_stack_push(o_stack_push), .i_stack_data(o_stack_data),
        .i_stack_pop(o_stack_pop), .i_vec_rd(o_vec_rd),
        .i_vec_addr(o_vec_addr), .i_macro_req(o_macro_req),
        .o_vec_valid(i_vec_valid), .o_vec_data(i_vec_data),
        .o_stack_valid(i_stack_valid), .o_stack_data(i_stack_data),
        .o_macro_ack(i_macro_ack));
    // ********
    // helpers
    // ********
    task automatic finish_test();
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [CTX_W-1:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle outputs may already be up when the caller arrives
    task automatic wait_ev(input int k);
        for (int i = 0; i < 40; i++) begin
            if (ev[k] === 1'b1) return;
            @(negedge i_clk);
        end
        chk(0, 1);
        finish_test();
    endtask
    task automatic fire(input logic [7:0] q, input logic [N_SRC-1:0] m);
        @(negedge i_clk);
        pulse = q;
        i_mask_req = m;
        @(negedge i_clk);
        pulse = '0;
        i_mask_req = '0;
    endtask
    task automatic vec_flow(input logic [VEC_W-1:0] v);
        wait_ev(0);
        chk(o_stack_data, {i_program_status_word, i_pc});
        wait_ev(2);
        chk(o_vec_addr, v);
        wait_ev(3);
        chk(o_branch_addr, v ^ 16'h8000);
        wait_ev(6);
    endtask
    task automatic refused(input logic [7:0] q, input logic [N_SRC-1:0] m);
        int c;
        c = push_cnt;
        fire(q, m);
        repeat (20) @(negedge i_clk);
        chk(push_cnt, c);
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        for (n = 0; n < 21; n++) rows[n] = '{8'h00, SRC_W'(n), VEC_TAB[n]};
        rows[21] = '{8'h02, 5'h00, 16'h003e};
        rows[22] = '{8'h04, 5'h00, 16'h003c};
        rows[23] = '{8'h08, 5'h00, 16'h0002};
        rows[24] = '{8'h10, 5'h00, 16'h0004};
        repeat (16) @(negedge i_clk);
        chk({o_busy, o_stack_push, o_vec_rd, o_branch, o_macro_req}, 0);
        i_rst = 1'b0;
        for (n = 0; n < 25; n++) begin
            i_pc = 20'h10000 + 20'(n);
            i_program_status_word = 16'ha500 + 16'(n);
            fire(rows[n].p, rows[n].p == 0 ? N_SRC'(1) << rows[n].src : '0);
            vec_flow(rows[n].vec);
        end
        repeat (10) @(negedge i_clk);
        chk(push_cnt, 25);
        for (n = 24; n > 22; n--) begin
            delay = (n == 23) ? 2'h2 : 2'h0;
            fire(8'h40, '0);
            wait_ev(1);
            chk(o_stack_pop, 1'b1);
            wait_ev(5);
            chk({o_resume_psw, o_resume_pc},
                {16'ha500 + 16'(n), 20'h10000 + 20'(n)});
            wait_ev(6);
        end
        fire(8'h00, 21'h000088);
        vec_flow(16'h000c);
        vec_flow(16'h0014);
        i_level = {21{2'b01}};
        i_level[18+:2] = 2'b00;
        fire(8'h00, 21'h000204);
        vec_flow(16'h0018);
        vec_flow(16'h000a);
        i_service_level = 3'h1;
        refused(8'h00, 21'h000004);
        i_service_level = 3'h4;
        vec_flow(16'h000a);
        i_level = '0;
        i_mask = '1;
        i_irq_enable = 1'b0;
        refused(8'h00, 21'h000001);
        fire(8'h08, '0);
        vec_flow(16'h0002);
        i_mask = '0;
        i_irq_enable = 1'b1;
        vec_flow(16'h0006);
        for (n = 0; n < 2; n++) begin
            i_wdt_first = n[0];
            fire(8'h18, '0);
            vec_flow(n ? 16'h0004 : 16'h0002);
            vec_flow(n ? 16'h0002 : 16'h0004);
        end
        i_imm_check = 8'ha5;
        refused(8'h04, '0);
        i_compare[15:0] = 16'h0000;
        vec_flow(16'h000e);
        i_timer_wide = 4'hd;
        i_compare[32+:16] = 16'h7734;
        vec_flow(16'h0012);
        i_timer_wide = 4'hf;
        i_compare[32+:16] = 16'h8834;
        refused(8'h00, '0);
        i_compare[32+:16] = 16'h1234;
        vec_flow(16'h0012);
        p = push_cnt;
        i_macro_sel = 21'h002000;
        i_irq_enable = 1'b0;
        i_service_level = 3'h0;
        fire(8'h00, 21'h002000);
        wait_ev(4);
        chk(o_macro_src, 5'h0d);
        wait_ev(6);
        chk(push_cnt, p);
        i_irq_enable = 1'b1;
        i_service_level = 3'h4;
        i_macro_sel = 21'h004000;
        fire(8'h00, 21'h004000);
        vec_flow(16'h0022);
        i_macro_sel = '0;
        i_ctx_sel = 21'h000004;
        i_bank_vec_we = 1'b1;
        @(negedge i_clk);
        i_bank_vec_addr = 3'h5;
        i_bank_vec_data = 16'h5a5a;
        @(negedge i_clk);
        i_bank_vec_we = 1'b0;
        p = push_cnt;
        i_pc = 20'h2abcd;
        i_program_status_word = 16'h3c3c;
        fire(8'h00, 21'h000004);
        wait_ev(3);
        chk(o_branch_addr, 16'h4321);
        wait_ev(6);
        i_pc = 20'h00000;
        fire(8'h80, '0);
        wait_ev(5);
        chk({o_resume_psw, o_resume_pc}, {16'h3c3c, 20'h2abcd});
        wait_ev(6);
        fire(8'h20, '0);
        wait_ev(3);
        chk(o_branch_addr, 16'h5a5a);
        wait_ev(6);
        chk(push_cnt, p);
        finish_test();
    end
endmodule
